// [bench/ccfg_host.sv]
// host chipset model issuing single-cycle i/o strobes
`timescale 1ns/1ns

module ccfg_host (
    input wire logic ref_clk,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid,
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    initial
    begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // one strobe cycle through the index or data port, answer one cycle later
    task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic v);
        @(posedge ref_clk);
        io_addr <= a;
        io_wr <= w;
        io_rd <= !w;
        io_wdata <= d;
        @(posedge ref_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
        #1;
        q = io_rdata;
        v = io_rdata_valid;
    endtask
endmodule // ccfg_host

// [bench/config_port_index_data_access_test.sv]
// self-checking bench of the configuration access unit
`timescale 1ns/1ns

module config_port_index_data_access_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic standby_power_on_reset = 1'b0;
    logic soft_reset = 1'b0;
    logic base_low_strap = 1'b0;
    logic base_high_strap = 1'b0;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_rdata_valid;
    logic config_state;
    logic [15:0] config_base_addr;
    logic [2:0] device_active;
    logic [7:0] keyboard_reset_gate_select;
    int fails = 0;
    int n_tests = 0;
    int cyc_cnt = 0;
    logic [15:0] base;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] nl;
    logic [7:0] nh;
    logic [2:0] act;
    logic [7:0] lds [3] = '{8'h05, 8'h07, 8'h0A};

    always #20 ref_clk = ~ref_clk;

    ccfg_access i_ccfg_access (.ref_clk(ref_clk), .rst(rst),
        .standby_power_on_reset(standby_power_on_reset), .soft_reset(soft_reset),
        .base_low_strap(base_low_strap), .base_high_strap(base_high_strap),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .config_state(config_state),
        .config_base_addr(config_base_addr), .device_active(device_active),
        .keyboard_reset_gate_select(keyboard_reset_gate_select));

    ccfg_host i_ccfg_host (.ref_clk(ref_clk), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata));

    function automatic logic [15:0] f_base(input logic lo, input logic hi);
        return {(hi ? 8'h00 : 8'h16), (lo ? 8'h4E : 8'h2E)};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        i_ccfg_host.cyc(1'b1, a, d, q, v);
    endtask

    task automatic rd_ck(input logic [15:0] a, input logic ve, input logic [7:0] de);
        logic [7:0] q;
        logic v;
        i_ccfg_host.cyc(1'b0, a, 8'h00, q, v);
        ck({15'h0000, v}, {15'h0000, ve});
        if (ve)
            ck({8'h00, q}, {8'h00, de});
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        wr(base, idx);
        wr(base + 16'h0001, d);
    endtask

    task automatic reg_ck(input logic [7:0] idx, input logic [7:0] d);
        wr(base, idx);
        rd_ck(base, 1'b1, idx);
        rd_ck(base + 16'h0001, 1'b1, d);
    endtask

    task automatic do_reset(input logic lo, input logic hi, input logic sb);
        @(posedge ref_clk);
        base_low_strap <= lo;
        base_high_strap <= hi;
        if (sb)
            standby_power_on_reset <= 1'b1;
        else
            rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        standby_power_on_reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        base = f_base(lo, hi);
        ck(config_base_addr, base);
        ck({15'h0000, config_state}, 16'h0000);
        ck({13'h0000, device_active}, 16'h0000);
        $display("reset test done");
    endtask

    always @(posedge ref_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        void'($urandom(25553));
        for (int k = 0; k < 4; k++)
            do_reset(k[0], k[1], 1'b0);
        rd_ck(base + 16'h0001, 1'b0, 8'h00);
        wr(base, 8'hAA);
        wr(base, 8'h3C);
        ck({15'h0000, config_state}, 16'h0000);
        wr(base, 8'h55);
        ck({15'h0000, config_state}, 16'h0001);
        $display("key test done");
        for (int j = 0; j < 3; j++)
        begin
            r1 = 8'($urandom);
            act[j] = r1[0];
            reg_wr(8'h07, lds[j]);
            reg_ck(8'h30, 8'h00);
            reg_wr(8'h30, r1);
            reg_ck(8'h30, r1);
        end
        ck({13'h0000, device_active}, {13'h0000, act});
        reg_wr(8'h07, 8'h05);
        reg_ck(8'hF1, 8'h02);
        reg_ck(8'hF2, 8'h03);
        r1 = 8'($urandom);
        r2 = 8'($urandom);
        reg_wr(8'hF1, r1);
        reg_wr(8'h07, 8'h07);
        reg_wr(8'h72, r1);
        reg_ck(8'h72, r1);
        reg_wr(8'hF0, r2);
        ck({8'h00, keyboard_reset_gate_select}, {8'h00, r2});
        $display("register test done");
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        @(posedge ref_clk);
        ck({13'h0000, device_active}, 16'h0000);
        ck({8'h00, keyboard_reset_gate_select}, {8'h00, r2});
        ck({15'h0000, config_state}, 16'h0001);
        reg_ck(8'h30, 8'h00);
        reg_ck(8'h72, 8'h00);
        reg_wr(8'h07, 8'h05);
        reg_ck(8'hF1, r1);
        reg_ck(8'hF2, 8'h03);
        $display("soft reset test done");
        nl = 8'($urandom) & 8'hFE;
        nh = 8'($urandom);
        reg_wr(8'h26, nl);
        base = {base[15:8], nl};
        ck(config_base_addr, base);
        reg_wr(8'h27, nh);
        base = {nh, nl};
        ck(config_base_addr, base);
        reg_ck(8'h26, nl);
        wr(base, 8'hAA);
        ck({15'h0000, config_state}, 16'h0000);
        rd_ck(base + 16'h0001, 1'b0, 8'h00);
        $display("relocate test done");
        do_reset(1'b1, 1'b0, 1'b1);
        complete_run();
    end
endmodule // config_port_index_data_access_test

// [rtl/ccfg_access.sv]
// configuration port index/data access unit
// Operation
// RULE_01 - after bus or main power-on reset the unit is in run mode with every device disabled.
// RULE_02 - the index and data ports act only while the unit is in configuration state.
// RULE_03 - the low strap picks 0x2E when low and 0x4E when high for port address bits 7:0.
// RULE_04 - the high strap picks 0x16 when low and 0x00 when high for port address bits 15:8.
// RULE_05 - both straps are captured on reset release and form the power-up port base address.
// RULE_06 - the port base can later be moved by writing indices 0x26 and 0x27.
// RULE_07 - writing 0x55 to the config port enters configuration state.
// RULE_08 - writing 0xAA to the config port returns to run mode.
// RULE_09 - devices are configured through one index port and one data port only.
// RULE_10 - infrared options reset to 0x02 and timeout to 0x03, both kept on soft reset.
// RULE_11 - activate, base address and interrupt select clear on every reset including soft.
// RULE_12 - the keyboard device has a cpu reset and a20 gate select at 0xF0, kept on soft reset.
// RULE_13 - the data port sits one above the index port and reaches the last written index.
// RULE_14 - in run mode any config port write other than the entry key is ignored.
`timescale 1ns/1ns
`include "ccfg_params.svh"

module ccfg_access (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic standby_power_on_reset,
    input wire logic soft_reset,
    input wire logic base_low_strap,
    input wire logic base_high_strap,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    output logic config_state,
    output logic [15:0] config_base_addr,
    output logic [2:0] device_active,
    output logic [7:0] keyboard_reset_gate_select
);

    localparam int N = `CCFG_SLOT_COUNT;

    function automatic logic [N-1:0][7:0] reset_table();
        logic [N-1:0][7:0] t;
        t = '0;
        t[`CCFG_SLOT_IR_OPTIONS] = `CCFG_RST_IR_OPTIONS;
        t[`CCFG_SLOT_IR_TIMEOUT] = `CCFG_RST_IR_TIMEOUT;
        return t;
    endfunction

    function automatic logic [N-1:0] keep_table();
        logic [N-1:0] k;
        k = '0;
        k[`CCFG_SLOT_INDEX] = 1'b1;
        k[`CCFG_SLOT_LDN] = 1'b1;
        k[`CCFG_SLOT_BASE_LOW] = 1'b1;
        k[`CCFG_SLOT_BASE_HIGH] = 1'b1;
        k[`CCFG_SLOT_S2_MODE] = 1'b1;
        k[`CCFG_SLOT_IR_OPTIONS] = 1'b1;
        k[`CCFG_SLOT_IR_TIMEOUT] = 1'b1;
        k[`CCFG_SLOT_KB_GATE] = 1'b1;
        return k;
    endfunction

    // maps device number and index onto a register slot
    function automatic logic [4:0] slot_of(input logic [7:0] ldn, input logic [7:0] idx);
        logic [4:0] r;
        r = `CCFG_SLOT_NONE;
        if (idx == `CCFG_IDX_LDN)
            r = `CCFG_SLOT_LDN;
        else if (idx == `CCFG_IDX_BASE_LOW)
            r = `CCFG_SLOT_BASE_LOW;
        else if (idx == `CCFG_IDX_BASE_HIGH)
            r = `CCFG_SLOT_BASE_HIGH;
        else if (ldn == `CCFG_LD_SERIAL2)
        begin
            if (idx == `CCFG_IDX_ACTIVATE)
                r = `CCFG_SLOT_S2_ACT;
            else if (idx == `CCFG_IDX_BASE_ADDR_HIGH)
                r = `CCFG_SLOT_S2_BASE_HIGH;
            else if (idx == `CCFG_IDX_BASE_ADDR_LOW)
                r = `CCFG_SLOT_S2_BASE_LOW;
            else if (idx == `CCFG_IDX_IRQ_PRIMARY)
                r = `CCFG_SLOT_S2_IRQ;
            else if (idx == `CCFG_IDX_MODE)
                r = `CCFG_SLOT_S2_MODE;
            else if (idx == `CCFG_IDX_IR_OPTIONS)
                r = `CCFG_SLOT_IR_OPTIONS;
            else if (idx == `CCFG_IDX_IR_TIMEOUT)
                r = `CCFG_SLOT_IR_TIMEOUT;
        end
        else if (ldn == `CCFG_LD_KEYBOARD)
        begin
            if (idx == `CCFG_IDX_ACTIVATE)
                r = `CCFG_SLOT_KB_ACT;
            else if (idx == `CCFG_IDX_IRQ_PRIMARY)
                r = `CCFG_SLOT_KB_IRQ;
            else if (idx == `CCFG_IDX_IRQ_SECONDARY)
                r = `CCFG_SLOT_MOUSE_IRQ;
            else if (idx == `CCFG_IDX_MODE)
                r = `CCFG_SLOT_KB_GATE; // RULE_12
        end
        else if (ldn == `CCFG_LD_RUNTIME)
        begin
            if (idx == `CCFG_IDX_ACTIVATE)
                r = `CCFG_SLOT_RT_ACT;
            else if (idx == `CCFG_IDX_BASE_ADDR_HIGH)
                r = `CCFG_SLOT_RT_BASE_HIGH;
            else if (idx == `CCFG_IDX_BASE_ADDR_LOW)
                r = `CCFG_SLOT_RT_BASE_LOW;
        end
        return r;
    endfunction

    ccfg_pkg::ccfg_main_s s_q;
    ccfg_pkg::ccfg_main_s s_d;

    logic strap_done;
    logic base_load;
    logic [15:0] base_value;
    logic [N-1:0][7:0] regs;
    logic [7:0] rd_data;
    logic [15:0] base_addr;
    logic [15:0] data_addr;
    logic hit_index;
    logic hit_data;
    logic [4:0] data_slot;
    logic wr_en;
    logic [4:0] wr_slot;
    logic [4:0] rd_slot;
    logic is_config;

    ccfg_strap u_strap (
        .ref_clk(ref_clk),
        .rst(rst),
        .standby_power_on_reset(standby_power_on_reset),
        .base_low_strap(base_low_strap),
        .base_high_strap(base_high_strap),
        .strap_done(strap_done),
        .base_load(base_load),
        .base_value(base_value)
    );

    ccfg_regfile #(
        .N(N),
        .RESET_VAL(reset_table()),
        .SOFT_KEEP(keep_table())
    ) u_regs (
        .ref_clk(ref_clk),
        .rst(rst),
        .standby_power_on_reset(standby_power_on_reset),
        .soft_reset(soft_reset),
        .wr_en(wr_en),
        .wr_slot(wr_slot),
        .wr_data(io_wdata),
        .base_load(base_load),
        .base_value(base_value),
        .rd_slot(rd_slot),
        .rd_data(rd_data),
        .regs(regs)
    );

    // port decode, base relocatable through two registers
    assign base_addr = {regs[`CCFG_SLOT_BASE_HIGH], regs[`CCFG_SLOT_BASE_LOW]}; // RULE_06
    assign data_addr = base_addr + 16'h0001; // RULE_13
    assign hit_index = strap_done && io_addr == base_addr; // RULE_09
    assign hit_data = strap_done && io_addr == data_addr; // RULE_09
    assign data_slot = slot_of(regs[`CCFG_SLOT_LDN], regs[`CCFG_SLOT_INDEX]); // RULE_13
    assign is_config = s_q.st == ccfg_pkg::CCFG_CONFIG;

    always_comb
    begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        wr_en = 1'b0;
        wr_slot = `CCFG_SLOT_NONE;
        rd_slot = `CCFG_SLOT_NONE;
        case (s_q.st)
            ccfg_pkg::CCFG_RUN:
            begin
                if (io_wr && hit_index && io_wdata == `CCFG_KEY_ENTER)
                    s_d.st = ccfg_pkg::CCFG_CONFIG; // RULE_07
                // other writes and all reads leave run mode untouched
            end
            ccfg_pkg::CCFG_CONFIG:
            begin
                if (io_wr && hit_index)
                begin
                    if (io_wdata == `CCFG_KEY_EXIT)
                        s_d.st = ccfg_pkg::CCFG_RUN; // RULE_08
                    else
                    begin
                        wr_en = 1'b1; // RULE_02
                        wr_slot = `CCFG_SLOT_INDEX;
                    end
                end
                else if (io_wr && hit_data && data_slot != `CCFG_SLOT_NONE)
                begin
                    wr_en = 1'b1; // RULE_13
                    wr_slot = data_slot;
                end
                else if (io_rd && hit_index)
                begin
                    rd_slot = `CCFG_SLOT_INDEX;
                    s_d.rvalid = 1'b1;
                end
                else if (io_rd && hit_data)
                begin
                    rd_slot = data_slot; // RULE_13
                    s_d.rvalid = 1'b1;
                end
            end
            default:
                s_d.st = ccfg_pkg::CCFG_RUN;
        endcase
        if (standby_power_on_reset)
        begin
            s_d.st = ccfg_pkg::CCFG_RUN; // RULE_01
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_q <= '{st: ccfg_pkg::CCFG_RUN, rvalid: 1'b0}; // RULE_01
        else
            s_q <= s_d;
    end

    assign io_rdata = rd_data;
    assign io_rdata_valid = s_q.rvalid;
    assign config_state = is_config;
    assign config_base_addr = base_addr;
    assign device_active = {regs[`CCFG_SLOT_RT_ACT][0], regs[`CCFG_SLOT_KB_ACT][0],
        regs[`CCFG_SLOT_S2_ACT][0]}; // RULE_01
    assign keyboard_reset_gate_select = regs[`CCFG_SLOT_KB_GATE]; // RULE_12

    sequence s_enter_write;
        !is_config && io_wr && hit_index && io_wdata == `CCFG_KEY_ENTER;
    endsequence

    sequence s_exit_write;
        is_config && io_wr && hit_index && io_wdata == `CCFG_KEY_EXIT;
    endsequence

    property p_enter_key;
        @(posedge ref_clk) disable iff (rst)
        s_enter_write ##0 !standby_power_on_reset |=> config_state;
    endproperty
    a_enter_key: assert property (p_enter_key) else $error("entry key not taken"); // RULE_07

    property p_exit_key;
        @(posedge ref_clk) disable iff (rst)
        s_exit_write |=> !config_state && !io_rdata_valid;
    endproperty
    a_exit_key: assert property (p_exit_key) else $error("exit key not taken"); // RULE_08

    property p_run_ignore;
        @(posedge ref_clk) disable iff (rst)
        !is_config && !standby_power_on_reset
            && !(io_wr && hit_index && io_wdata == `CCFG_KEY_ENTER) |=>
            !config_state && regs[`CCFG_SLOT_INDEX] == $past(regs[`CCFG_SLOT_INDEX]);
    endproperty
    a_run_ignore: assert property (p_run_ignore) else $error("run mode write acted"); // RULE_14

    property p_run_no_read;
        @(posedge ref_clk) disable iff (rst)
        !is_config |=> !io_rdata_valid;
    endproperty
    a_run_no_read: assert property (p_run_no_read) else $error("read answered in run"); // RULE_02

    property p_read_answer;
        @(posedge ref_clk) disable iff (rst)
        is_config && io_rd && !io_wr && (hit_index || hit_data) && !standby_power_on_reset
            |=> io_rdata_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered"); // RULE_02

    property p_index_readback;
        @(posedge ref_clk) disable iff (rst)
        is_config && io_wr && hit_index && io_wdata != `CCFG_KEY_EXIT && !soft_reset
            && !standby_power_on_reset ##1 !io_wr && !standby_power_on_reset
            ##1 is_config && io_rd && !io_wr && hit_index && !standby_power_on_reset
            |=> io_rdata_valid && io_rdata == $past(io_wdata, 3);
    endproperty
    a_index_readback: assert property (p_index_readback) else $error("index readback wrong"); // RULE_13

    property p_gate_write;
        @(posedge ref_clk) disable iff (rst)
        is_config && io_wr && hit_data && data_slot == `CCFG_SLOT_KB_GATE
            && !standby_power_on_reset |=> keyboard_reset_gate_select == $past(io_wdata);
    endproperty
    a_gate_write: assert property (p_gate_write) else $error("gate select not written"); // RULE_12

    property p_relocate;
        @(posedge ref_clk) disable iff (rst)
        is_config && io_wr && hit_data && regs[`CCFG_SLOT_INDEX] == `CCFG_IDX_BASE_LOW
            && !base_load && !standby_power_on_reset
            |=> config_base_addr[7:0] == $past(io_wdata) ##1 data_addr[7:0] != 8'h00
            || config_base_addr[7:0] == 8'hFF || standby_power_on_reset || $past(base_load);
    endproperty
    a_relocate: assert property (p_relocate) else $error("base not relocated"); // RULE_06

    property p_standby_run;
        @(posedge ref_clk) disable iff (rst)
        standby_power_on_reset |=> !config_state && device_active == 3'h0;
    endproperty
    a_standby_run: assert property (p_standby_run) else $error("not in run after reset"); // RULE_01

endmodule // ccfg_access

// [rtl/ccfg_params.svh]
// constants of the configuration access unit
`ifndef CCFG_PARAMS_SVH
`define CCFG_PARAMS_SVH

`define CCFG_KEY_ENTER 8'h55
`define CCFG_KEY_EXIT 8'hAA

`define CCFG_STRAP_LOW_0 8'h2E
`define CCFG_STRAP_LOW_1 8'h4E
`define CCFG_STRAP_HIGH_0 8'h16
`define CCFG_STRAP_HIGH_1 8'h00
`define CCFG_STRAP_SETTLE 2'h2

`define CCFG_IDX_LDN 8'h07
`define CCFG_IDX_BASE_LOW 8'h26
`define CCFG_IDX_BASE_HIGH 8'h27
`define CCFG_IDX_ACTIVATE 8'h30
`define CCFG_IDX_BASE_ADDR_HIGH 8'h60
`define CCFG_IDX_BASE_ADDR_LOW 8'h61
`define CCFG_IDX_IRQ_PRIMARY 8'h70
`define CCFG_IDX_IRQ_SECONDARY 8'h72
`define CCFG_IDX_MODE 8'hF0
`define CCFG_IDX_IR_OPTIONS 8'hF1
`define CCFG_IDX_IR_TIMEOUT 8'hF2

`define CCFG_LD_SERIAL2 8'h05
`define CCFG_LD_KEYBOARD 8'h07
`define CCFG_LD_RUNTIME 8'h0A

`define CCFG_RST_IR_OPTIONS 8'h02
`define CCFG_RST_IR_TIMEOUT 8'h03
`define CCFG_RST_ZERO 8'h00

`define CCFG_SLOT_INDEX 5'h00
`define CCFG_SLOT_LDN 5'h01
`define CCFG_SLOT_BASE_LOW 5'h02
`define CCFG_SLOT_BASE_HIGH 5'h03
`define CCFG_SLOT_S2_ACT 5'h04
`define CCFG_SLOT_S2_BASE_HIGH 5'h05
`define CCFG_SLOT_S2_BASE_LOW 5'h06
`define CCFG_SLOT_S2_IRQ 5'h07
`define CCFG_SLOT_S2_MODE 5'h08
`define CCFG_SLOT_IR_OPTIONS 5'h09
`define CCFG_SLOT_IR_TIMEOUT 5'h0A
`define CCFG_SLOT_KB_ACT 5'h0B
`define CCFG_SLOT_KB_IRQ 5'h0C
`define CCFG_SLOT_MOUSE_IRQ 5'h0D
`define CCFG_SLOT_KB_GATE 5'h0E
`define CCFG_SLOT_RT_ACT 5'h0F
`define CCFG_SLOT_RT_BASE_HIGH 5'h10
`define CCFG_SLOT_RT_BASE_LOW 5'h11
`define CCFG_SLOT_COUNT 18
`define CCFG_SLOT_NONE 5'h12

`endif

// [rtl/ccfg_pkg.sv]
// types of the configuration access unit
package ccfg_pkg;

    typedef enum logic [1:0] {
        CCFG_RUN = 2'b01,
        CCFG_CONFIG = 2'b10
    } ccfg_state_e;

    typedef struct packed {
        ccfg_state_e st;
        logic rvalid;
    } ccfg_main_s;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] settle;
        logic done;
        logic load;
        logic [15:0] value;
    } ccfg_strap_s;

endpackage

// [rtl/ccfg_regfile.sv]
// configuration register bank with per-reset defaults and registered read
`timescale 1ns/1ns
`include "ccfg_params.svh"

module ccfg_regfile #(
    parameter int N = `CCFG_SLOT_COUNT,
    parameter logic [N-1:0][7:0] RESET_VAL = '0,
    parameter logic [N-1:0] SOFT_KEEP = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic standby_power_on_reset,
    input wire logic soft_reset,
    input wire logic wr_en,
    input wire logic [4:0] wr_slot,
    input wire logic [7:0] wr_data,
    input wire logic base_load,
    input wire logic [15:0] base_value,
    input wire logic [4:0] rd_slot,
    output logic [7:0] rd_data,
    output logic [N-1:0][7:0] regs
);

    if (N < 4 || N > 31)
        $error("ccfg_regfile: N out of range");

    typedef struct packed {
        logic [N-1:0][7:0] regs;
        logic [7:0] rdata;
    } ccfg_rf_s;

    ccfg_rf_s s_q;
    ccfg_rf_s s_d;
    logic [N-1:0][7:0] slot_d;

    for (genvar i = 0; i < N; i++)
    begin : g_slot
        always_comb
        begin
            if (standby_power_on_reset)
                slot_d[i] = RESET_VAL[i]; // RULE_10
            else if (soft_reset && !SOFT_KEEP[i])
                slot_d[i] = RESET_VAL[i]; // RULE_11
            else if (base_load && i == int'(`CCFG_SLOT_BASE_LOW))
                slot_d[i] = base_value[7:0];
            else if (base_load && i == int'(`CCFG_SLOT_BASE_HIGH))
                slot_d[i] = base_value[15:8];
            else if (wr_en && int'(wr_slot) == i)
                slot_d[i] = wr_data;
            else
                slot_d[i] = s_q.regs[i];
        end
    end

    always_comb
    begin
        s_d.regs = slot_d;
        s_d.rdata = (int'(rd_slot) < N) ? s_q.regs[rd_slot] : 8'h00;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q.regs <= RESET_VAL;
            s_q.rdata <= 8'h00;
        end
        else
            s_q <= s_d;
    end

    assign rd_data = s_q.rdata;
    assign regs = s_q.regs;

    property p_soft_keep_ir;
        @(posedge ref_clk) disable iff (rst)
        soft_reset && !standby_power_on_reset && !wr_en |=>
            regs[`CCFG_SLOT_IR_OPTIONS] == $past(regs[`CCFG_SLOT_IR_OPTIONS])
            && regs[`CCFG_SLOT_IR_TIMEOUT] == $past(regs[`CCFG_SLOT_IR_TIMEOUT]);
    endproperty
    a_soft_keep_ir: assert property (p_soft_keep_ir) else $error("ir lost on soft reset"); // RULE_10

    property p_soft_clear_act;
        @(posedge ref_clk) disable iff (rst)
        soft_reset |=> regs[`CCFG_SLOT_KB_ACT] == 8'h00 && regs[`CCFG_SLOT_RT_ACT] == 8'h00
            && regs[`CCFG_SLOT_KB_IRQ] == 8'h00 && regs[`CCFG_SLOT_RT_BASE_LOW] == 8'h00;
    endproperty
    a_soft_clear_act: assert property (p_soft_clear_act) else $error("soft reset kept"); // RULE_11

    property p_standby_ir;
        @(posedge ref_clk) disable iff (rst)
        standby_power_on_reset |=> regs[`CCFG_SLOT_IR_OPTIONS] == `CCFG_RST_IR_OPTIONS
            && regs[`CCFG_SLOT_IR_TIMEOUT] == `CCFG_RST_IR_TIMEOUT;
    endproperty
    a_standby_ir: assert property (p_standby_ir) else $error("ir default wrong"); // RULE_10

endmodule // ccfg_regfile

// [rtl/ccfg_strap.sv]
// strap synchroniser and power-up base address capture
`timescale 1ns/1ns
`include "ccfg_params.svh"

module ccfg_strap (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic standby_power_on_reset,
    input wire logic base_low_strap,
    input wire logic base_high_strap,
    output logic strap_done,
    output logic base_load,
    output logic [15:0] base_value
);

    ccfg_pkg::ccfg_strap_s s_q;
    ccfg_pkg::ccfg_strap_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.sync1 = {base_high_strap, base_low_strap};
        s_d.sync2 = s_q.sync1;
        s_d.load = 1'b0;
        if (standby_power_on_reset)
        begin
            s_d.done = 1'b0;
            s_d.settle = 2'h0;
        end
        else if (!s_q.done)
        begin
            if (s_q.settle == `CCFG_STRAP_SETTLE)
            begin
                s_d.done = 1'b1; // RULE_05
                s_d.load = 1'b1;
                s_d.value[7:0] = s_q.sync2[0] ? `CCFG_STRAP_LOW_1 : `CCFG_STRAP_LOW_0; // RULE_03
                s_d.value[15:8] = s_q.sync2[1] ? `CCFG_STRAP_HIGH_1 : `CCFG_STRAP_HIGH_0; // RULE_04
            end
            else
            begin
                s_d.settle = s_q.settle + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign strap_done = s_q.done;
    assign base_load = s_q.load;
    assign base_value = s_q.value;

    sequence s_settled;
        !s_q.done && s_q.settle == `CCFG_STRAP_SETTLE && !standby_power_on_reset;
    endsequence

    property p_strap_capture;
        @(posedge ref_clk) disable iff (rst)
        s_settled |=> base_load && strap_done
            ##1 !base_load && (strap_done || $past(standby_power_on_reset));
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap capture missed"); // RULE_05

    property p_strap_low;
        @(posedge ref_clk) disable iff (rst)
        s_settled |=> base_value[7:0] ==
            ($past(s_q.sync2[0]) ? `CCFG_STRAP_LOW_1 : `CCFG_STRAP_LOW_0);
    endproperty
    a_strap_low: assert property (p_strap_low) else $error("low base byte wrong"); // RULE_03

    property p_strap_high;
        @(posedge ref_clk) disable iff (rst)
        s_settled |=> base_value[15:8] ==
            ($past(s_q.sync2[1]) ? `CCFG_STRAP_HIGH_1 : `CCFG_STRAP_HIGH_0);
    endproperty
    a_strap_high: assert property (p_strap_high) else $error("high base byte wrong"); // RULE_04

endmodule // ccfg_strap
